// >>> common/cra_regs.vh
`ifndef CRA_REGS_VH
`define CRA_REGS_VH

// ==================================================
// Register widths
`define CRA_WORD_W        24
`define CRA_DBL_W         47
`define CRA_PC_W          16
`define CRA_COND_W        4
`define CRA_ADDR_W        18
`define CRA_SEL_W         4

// ==================================================
// Register select codes on the read port; the write port decodes all but CRA_SEL_INSTR
`define CRA_SEL_ACC       4'h0
`define CRA_SEL_BYTE      4'h1
`define CRA_SEL_EXT       4'h2
`define CRA_SEL_DBL       4'h3
`define CRA_SEL_IDX1      4'h4
`define CRA_SEL_IDX2      4'h5
`define CRA_SEL_IDX3      4'h6
`define CRA_SEL_COND      4'h7
`define CRA_SEL_PC        4'h8
`define CRA_SEL_INSTR     4'h9
`define CRA_SEL_SHIFT     4'hA

// ==================================================
// Condition flag positions
`define CRA_COND_OVF      0
`define CRA_COND_NEG      1
`define CRA_COND_ZERO     2
`define CRA_COND_POS      3

// ==================================================
// Instruction word fields
`define CRA_IN_IND        17
`define CRA_IN_X_HI       16
`define CRA_IN_X_LO       15
`define CRA_IN_DIR_HI     14
`define CRA_IN_LB_HI      15
`define CRA_IN_OPX        16
`define CRA_BYTE_HI       7
`define CRA_ACC_MSB       23

// ==================================================
// Indirect word fields
`define CRA_IW_MORE       23
`define CRA_IW_X_HI       22
`define CRA_IW_X_LO       21
`define CRA_IW_LONG       20
`define CRA_IW_STD_HI     15
`define CRA_IW_LONG_HI    17

// ==================================================
// Index field codes
`define CRA_X_NONE        2'h0
`define CRA_X_FIRST       2'h1
`define CRA_X_SECOND      2'h2
`define CRA_X_THIRD       2'h3

`endif

// >>> logic/cra_core.v
`timescale 1ns/1ns
`default_nettype none
`include "cra_regs.vh"

module cra_core (
    input  wire                      core_clk_i,
    input  wire                      reset_n_i,
    input  wire                      wr_en_i,
    input  wire [`CRA_SEL_W-1:0]     wr_sel_i,
    input  wire [`CRA_DBL_W-1:0]     wr_data_i,
    input  wire [`CRA_SEL_W-1:0]     rd_sel_i,
    output reg  [`CRA_DBL_W-1:0]     rd_data_o,
    input  wire                      cond_upd_i,
    input  wire [`CRA_COND_W-1:0]    cond_val_i,
    input  wire                      io_load_i,
    input  wire [`CRA_WORD_W-1:0]    io_data_i,
    output reg  [`CRA_WORD_W-1:0]    io_data_o,
    input  wire                      pc_inc_i,
    input  wire                      branch_i,
    input  wire                      branch_save_link_instr_i,
    input  wire [`CRA_PC_W-1:0]      branch_addr_i,
    output reg  [`CRA_PC_W-1:0]      link_o,
    output reg  [`CRA_ADDR_W-1:0]    fetch_addr_o,
    output reg                       fetch_xlate_o,
    input  wire                      instr_load_i,
    input  wire [`CRA_WORD_W-1:0]    instr_word_i,
    output reg  [`CRA_WORD_W-1:0]    instr_o,
    input  wire                      user_mode_i,
    input  wire                      agen_start_i,
    input  wire                      long_branch_i,
    output reg                       agen_busy_o,
    output reg                       mem_rd_o,
    output reg  [`CRA_ADDR_W-1:0]    mem_addr_o,
    output reg                       mem_xlate_o,
    input  wire                      mem_ack_i,
    input  wire [`CRA_WORD_W-1:0]    mem_rdata_i,
    output reg                       ea_valid_o,
    output reg  [`CRA_ADDR_W-1:0]    ea_o,
    output reg                       ea_xlate_o
);

    // ==================================================
    // Reset synchroniser
    reg                       rst_meta_n;
    reg                       rst_n;

    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // ==================================================
    // Programmer-visible registers
    reg  [`CRA_WORD_W-1:0]    acc;
    reg  [`CRA_WORD_W-1:0]    ext;
    reg  [`CRA_COND_W-1:0]    cond;
    reg  [`CRA_PC_W-1:0]      pc;
    reg  [`CRA_WORD_W-1:0]    instr;
    wire [3*`CRA_WORD_W-1:0]  idx_flat;

    wire wr_acc   = wr_en_i && (wr_sel_i == `CRA_SEL_ACC);
    wire wr_byte  = wr_en_i && (wr_sel_i == `CRA_SEL_BYTE);
    wire wr_ext   = wr_en_i && (wr_sel_i == `CRA_SEL_EXT);
    wire wr_dbl   = wr_en_i && (wr_sel_i == `CRA_SEL_DBL);
    wire wr_cond  = wr_en_i && (wr_sel_i == `CRA_SEL_COND);
    wire wr_pc    = wr_en_i && (wr_sel_i == `CRA_SEL_PC);
    wire wr_shift = wr_en_i && (wr_sel_i == `CRA_SEL_SHIFT);

    // Index register of a two-bit field; zero when no indexing
    function [`CRA_WORD_W-1:0] index_value;
        input [1:0]                 xsel;
        input [3*`CRA_WORD_W-1:0]   regs;
        begin
            case (xsel)
                `CRA_X_FIRST:  index_value = regs[`CRA_WORD_W-1:0];
                `CRA_X_SECOND: index_value = regs[2*`CRA_WORD_W-1:`CRA_WORD_W];
                `CRA_X_THIRD:  index_value = regs[3*`CRA_WORD_W-1:2*`CRA_WORD_W];
                default:       index_value = {`CRA_WORD_W{1'b0}};
            endcase
        end
    endfunction

    // Accumulator: word, byte and double views share the same flops
    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            acc <= 24'h000000;
        end else if (wr_acc) begin
            acc <= wr_data_i[`CRA_WORD_W-1:0];
        end else if (wr_byte) begin
            acc[`CRA_BYTE_HI:0] <= wr_data_i[`CRA_BYTE_HI:0];
        end else if (wr_dbl) begin
            acc[`CRA_ACC_MSB-1:0] <= wr_data_i[`CRA_ACC_MSB-1:0];
        end else if (io_load_i) begin
            acc <= io_data_i;
        end
    end

    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ext <= 24'h000000;
        end else if (wr_ext) begin
            ext <= wr_data_i[`CRA_WORD_W-1:0];
        end else if (wr_dbl) begin
            ext <= wr_data_i[`CRA_DBL_W-1:`CRA_ACC_MSB];
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : gen_idx
            reg [`CRA_WORD_W-1:0] value;
            wire hit = wr_en_i && (wr_sel_i == `CRA_SEL_IDX1 + g);
            always @(posedge core_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    value <= 24'h000000;
                end else if (hit) begin
                    value <= wr_data_i[`CRA_WORD_W-1:0];
                end
            end
            assign idx_flat[(g+1)*`CRA_WORD_W-1:g*`CRA_WORD_W] = value;
        end
    endgenerate

    // Flag order: overflow, negative, zero, positive from bit 0 up
    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cond <= 4'h0;
        end else if (cond_upd_i) begin
            cond <= cond_val_i;
        end else if (wr_cond) begin
            cond <= wr_data_i[`CRA_COND_W-1:0];
        end
    end

    // Branches beat a plain load, which beats the advance
    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pc     <= 16'h0000;
            link_o <= 16'h0000;
        end else if (branch_save_link_instr_i) begin
            link_o <= pc;
            pc     <= branch_addr_i;
        end else if (branch_i) begin
            pc <= branch_addr_i;
        end else if (wr_pc) begin
            pc <= wr_data_i[`CRA_PC_W-1:0];
        end else if (pc_inc_i) begin
            pc <= pc + 16'h0001;
        end
    end

    // Only the fetch path writes the whole word
    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            instr <= 24'h000000;
        end else if (instr_load_i) begin
            instr <= instr_word_i;
        end else if (wr_shift) begin
            instr[`CRA_BYTE_HI:0] <= wr_data_i[`CRA_BYTE_HI:0];
        end
    end

    // ==================================================
    // Read port and mirrored outputs
    reg [`CRA_DBL_W-1:0] next_rd_data;

    always @* begin
        next_rd_data = {`CRA_DBL_W{1'b0}};
        case (rd_sel_i)
            `CRA_SEL_ACC:   next_rd_data[`CRA_WORD_W-1:0] = acc;
            `CRA_SEL_BYTE:  next_rd_data[`CRA_BYTE_HI:0] = acc[`CRA_BYTE_HI:0];
            `CRA_SEL_EXT:   next_rd_data[`CRA_WORD_W-1:0] = ext;
            `CRA_SEL_DBL:   next_rd_data = {ext, acc[`CRA_ACC_MSB-1:0]};
            `CRA_SEL_IDX1:  next_rd_data[`CRA_WORD_W-1:0] = index_value(`CRA_X_FIRST, idx_flat);
            `CRA_SEL_IDX2:  next_rd_data[`CRA_WORD_W-1:0] = index_value(`CRA_X_SECOND, idx_flat);
            `CRA_SEL_IDX3:  next_rd_data[`CRA_WORD_W-1:0] = index_value(`CRA_X_THIRD, idx_flat);
            `CRA_SEL_COND:  next_rd_data[`CRA_COND_W-1:0] = cond;
            `CRA_SEL_PC:    next_rd_data[`CRA_PC_W-1:0] = pc;
            `CRA_SEL_INSTR: next_rd_data[`CRA_WORD_W-1:0] = instr;
            `CRA_SEL_SHIFT: next_rd_data[`CRA_BYTE_HI:0] = instr[`CRA_BYTE_HI:0];
            default:        next_rd_data = {`CRA_DBL_W{1'b0}};
        endcase
    end

    // Mirrors lag their register by one cycle
    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_o     <= 47'h000000000000;
            io_data_o     <= 24'h000000;
            instr_o       <= 24'h000000;
            fetch_addr_o  <= 18'h00000;
            fetch_xlate_o <= 1'b0;
        end else begin
            rd_data_o     <= next_rd_data;
            io_data_o     <= acc;
            instr_o       <= instr;
            fetch_addr_o  <= {2'b00, pc};
            fetch_xlate_o <= user_mode_i;
        end
    end

    // ==================================================
    // Effective address generation
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_WAIT = 3'b010;
    localparam [2:0] ST_DONE = 3'b100;

    reg  [2:0]               state;
    reg  [2:0]               next_state;
    reg  [`CRA_ADDR_W-1:0]   next_addr;
    reg                      next_more;
    reg  [`CRA_PC_W-1:0]     base16;
    reg  [`CRA_WORD_W-1:0]   xval;
    reg  [`CRA_WORD_W-1:0]   iw_xval;

    // Address of the first level, from the instruction
    always @* begin
        base16 = 16'h0000;
        xval   = {`CRA_WORD_W{1'b0}};
        if (long_branch_i) begin
            base16 = instr[`CRA_IN_LB_HI:0];
        end else begin
            base16 = {pc[`CRA_PC_W-1], instr[`CRA_IN_DIR_HI:0]};
            xval   = index_value(instr[`CRA_IN_X_HI:`CRA_IN_X_LO], idx_flat);
        end
    end

    // Next address of a chain: instruction level or indirect word
    always @* begin
        next_addr = {`CRA_ADDR_W{1'b0}};
        next_more = 1'b0;
        iw_xval   = index_value(mem_rdata_i[`CRA_IW_X_HI:`CRA_IW_X_LO], idx_flat);
        if (state == ST_IDLE) begin
            next_addr = {2'b00, base16 + xval[`CRA_PC_W-1:0]};
            next_more = instr[`CRA_IN_IND];
        end else if (mem_rdata_i[`CRA_IW_LONG]) begin
            next_addr = mem_rdata_i[`CRA_IW_LONG_HI:0] + iw_xval[`CRA_ADDR_W-1:0];
            next_more = mem_rdata_i[`CRA_IW_MORE];
        end else begin
            next_addr = {2'b00, mem_rdata_i[`CRA_IW_STD_HI:0] + iw_xval[`CRA_PC_W-1:0]};
            next_more = mem_rdata_i[`CRA_IW_MORE];
        end
    end

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (agen_start_i) begin
                    next_state = next_more ? ST_WAIT : ST_DONE;
                end
            end
            ST_WAIT: begin
                if (mem_ack_i) begin
                    next_state = next_more ? ST_WAIT : ST_DONE;
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Translation flag follows the mode at each request
    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state       <= ST_IDLE;
            agen_busy_o <= 1'b0;
            mem_rd_o    <= 1'b0;
            mem_addr_o  <= 18'h00000;
            mem_xlate_o <= 1'b0;
            ea_valid_o  <= 1'b0;
            ea_o        <= 18'h00000;
            ea_xlate_o  <= 1'b0;
        end else begin
            state      <= next_state;
            mem_rd_o   <= 1'b0;
            ea_valid_o <= 1'b0;
            agen_busy_o <= (next_state != ST_IDLE);
            if ((state == ST_IDLE && agen_start_i) || (state == ST_WAIT && mem_ack_i)) begin
                if (next_more) begin
                    mem_rd_o    <= 1'b1;
                    mem_addr_o  <= next_addr;
                    mem_xlate_o <= user_mode_i;
                end else begin
                    ea_valid_o  <= 1'b1;
                    ea_o        <= next_addr;
                    ea_xlate_o  <= user_mode_i;
                end
            end
        end
    end

endmodule // cra_core

`default_nettype wire

// >>> test/cra_core_checker.sv
`timescale 1ns/1ns
`default_nettype none
`include "cra_regs.vh"
module cra_core_checker (
    input wire logic        core_clk_i,
    input wire logic        reset_n_i,
    input wire logic        io_load_i,
    input wire logic [23:0] io_data_i,
    input wire logic [23:0] io_data_o,
    input wire logic        branch_save_link_instr_i,
    input wire logic [15:0] branch_addr_i,
    input wire logic [15:0] link_o,
    input wire logic [17:0] fetch_addr_o,
    input wire logic        fetch_xlate_o,
    input wire logic        instr_load_i,
    input wire logic [23:0] instr_word_i,
    input wire logic        user_mode_i,
    input wire logic [23:0] instr_o,
    input wire logic        agen_start_i,
    input wire logic        long_branch_i,
    input wire logic        agen_busy_o,
    input wire logic        mem_rd_o,
    input wire logic [17:0] mem_addr_o,
    input wire logic        mem_xlate_o,
    input wire logic        mem_ack_i,
    input wire logic [23:0] mem_rdata_i,
    input wire logic        ea_valid_o,
    input wire logic [17:0] ea_o,
    input wire logic        ea_xlate_o
);
    default clocking dc @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    // ==================================================
    // Address generation steps
    sequence s_start; agen_start_i && !agen_busy_o; endsequence
    sequence s_ack; mem_ack_i && agen_busy_o && !mem_rd_o; endsequence
    sequence s_done; ea_valid_o && agen_busy_o ##1 !agen_busy_o && !ea_valid_o; endsequence
    a_direct_bias: assert property (s_start ##0 (!long_branch_i && instr_o[17:15] == 3'h0) |=> ea_valid_o &&
        ea_o == {2'h0, $past(fetch_addr_o[15]), $past(instr_o[14:0])}) else $error("direct address wrong");
    a_long_branch: assert property (s_start ##0 (long_branch_i && !instr_o[17]) |=> ea_valid_o &&
        ea_o == {2'h0, $past(instr_o[15:0])}) else $error("long branch address wrong");
    a_indirect_go: assert property (s_start ##0 instr_o[17] |=> mem_rd_o && !ea_valid_o)
        else $error("indirect read missing");
    a_std_final: assert property (s_ack ##0 (mem_rdata_i[23:20] == 4'h0) |=> ea_valid_o &&
        ea_o == {2'h0, $past(mem_rdata_i[15:0])}) else $error("standard indirect wrong");
    a_long_final: assert property (s_ack ##0 (mem_rdata_i[23:20] == 4'h1) |=> ea_valid_o &&
        ea_o == $past(mem_rdata_i[17:0])) else $error("long indirect wrong");
    a_chain_more: assert property (s_ack ##0 (mem_rdata_i[23:20] == 4'h8) |=> mem_rd_o && !ea_valid_o &&
        mem_addr_o == {2'h0, $past(mem_rdata_i[15:0])}) else $error("indirect chain wrong");
    a_result_once: assert property (ea_valid_o |-> s_done) else $error("result pacing wrong");
    a_xlate_mode: assert property ((mem_rd_o -> mem_xlate_o == $past(user_mode_i)) &&
        (ea_valid_o -> ea_xlate_o == $past(user_mode_i))) else $error("translate flag wrong");
    a_fetch_mode: assert property (fetch_xlate_o == $past(user_mode_i))
        else $error("fetch translate flag wrong");
    a_instr_copy: assert property (instr_load_i |=> ##1 instr_o == $past(instr_word_i, 2))
        else $error("instruction copy wrong");
    a_fetch_range: assert property (fetch_addr_o[17:16] == 2'h0) else $error("fetch above 64K");
    a_io_copy: assert property (io_load_i |=> ##1 io_data_o == $past(io_data_i, 2))
        else $error("io data wrong");
    a_link_save: assert property (branch_save_link_instr_i |=> link_o == fetch_addr_o[15:0]
        ##1 fetch_addr_o[15:0] == $past(branch_addr_i, 2)) else $error("link save wrong");
endmodule // cra_core_checker
bind cra_core cra_core_checker chk (.core_clk_i, .reset_n_i, .io_load_i, .io_data_i, .io_data_o,
    .branch_save_link_instr_i, .branch_addr_i, .link_o, .fetch_addr_o, .fetch_xlate_o, .instr_load_i,
    .instr_word_i, .user_mode_i, .instr_o, .agen_start_i,
    .long_branch_i, .agen_busy_o, .mem_rd_o, .mem_addr_o, .mem_xlate_o, .mem_ack_i, .mem_rdata_i, .ea_valid_o,
    .ea_o, .ea_xlate_o);
`default_nettype wire

// >>> test/cra_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module cra_mem_model (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        rd_i,
    input wire logic [17:0] addr_i,
    input wire logic [2:0]  lat_i,
    output var logic        ack_o,
    output var logic [23:0] data_o
);
    logic [23:0] mem [int];
    logic [17:0] adr;
    logic [2:0]  cnt;
    // Data toggles when not answering, so a stale word never looks valid
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 3'h0;
            ack_o <= 1'b0;
            data_o <= 24'h0;
        end else begin
            ack_o <= 1'b0;
            data_o <= ~data_o;
            if (rd_i) begin
                cnt <= lat_i;
                adr <= addr_i;
            end else if (cnt != 3'h0) begin
                cnt <= cnt - 3'h1;
                if (cnt == 3'h1) begin
                    ack_o <= 1'b1;
                    data_o <= mem[adr];
                end
            end
        end
    end
endmodule // cra_mem_model
`default_nettype wire

// >>> test/cra_core_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "cra_regs.vh"
module cra_core_bench;
    logic core_clk_i = 0, reset_n_i = 0, wr_en_i = 0, cond_upd_i = 0, io_load_i = 0, pc_inc_i = 0;
    logic branch_i = 0, branch_save_link_instr_i = 0, instr_load_i = 0, user_mode_i = 0, agen_start_i = 0;
    logic long_branch_i = 0, rd_tag = 0, rd_tag_d = 0, mem_ack_i, fetch_xlate_o, agen_busy_o;
    logic mem_rd_o, mem_xlate_o, ea_valid_o, ea_xlate_o;
    logic [3:0]  wr_sel_i = 0, rd_sel_i = 0, cond_val_i = 0;
    logic [46:0] wr_data_i = 0, rd_data_o, d;
    logic [23:0] io_data_i = 0, io_data_o, instr_word_i = 0, instr_o, mem_rdata_i, acc, ir, w1, w2, xr [0:3];
    logic [15:0] branch_addr_i = 0, link_o, pc;
    logic [17:0] fetch_addr_o, mem_addr_o, ea_o, e0, e1, fin;
    logic [46:0] rd_q [$], ea_q [$];
    logic [31:0] seed = 32'h15, r;
    logic [2:0]  lat = 3'h1;
    int num_errors = 0, n_compared = 0, k;
    cra_core uut (.core_clk_i, .reset_n_i, .wr_en_i, .wr_sel_i, .wr_data_i, .rd_sel_i, .rd_data_o, .cond_upd_i,
        .cond_val_i, .io_load_i, .io_data_i, .io_data_o, .pc_inc_i, .branch_i, .branch_save_link_instr_i,
        .branch_addr_i, .link_o, .fetch_addr_o, .fetch_xlate_o, .instr_load_i, .instr_word_i, .instr_o,
        .user_mode_i, .agen_start_i, .long_branch_i, .agen_busy_o, .mem_rd_o, .mem_addr_o, .mem_xlate_o,
        .mem_ack_i, .mem_rdata_i, .ea_valid_o, .ea_o, .ea_xlate_o);
    cra_mem_model mdl (.clk_i(core_clk_i), .rst_n_i(reset_n_i), .rd_i(mem_rd_o), .addr_i(mem_addr_o),
        .lat_i(lat), .ack_o(mem_ack_i), .data_o(mem_rdata_i));
    always #50 core_clk_i = ~core_clk_i;
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic logic [17:0] dir_ea(input logic [23:0] w);
        return {2'h0, {pc[15], w[14:0]} + xr[w[16:15]][15:0]};
    endfunction
    task automatic check(input string nm, input logic [46:0] seen, input logic [46:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ==================================================
    // Bus tasks
    task automatic wr(input logic [3:0] s, input logic [46:0] v);
        @(posedge core_clk_i);
        wr_en_i <= 1;
        wr_sel_i <= s;
        wr_data_i <= v;
        @(posedge core_clk_i);
        wr_en_i <= 0;
    endtask
    task automatic rd(input logic [3:0] s, input logic [46:0] v);
        @(posedge core_clk_i);
        rd_sel_i <= s;
        rd_q.push_back(v);
        rd_tag <= 1;
        @(posedge core_clk_i);
        rd_tag <= 0;
    endtask
    task automatic setpc(input logic [15:0] a, input logic m);
        @(posedge core_clk_i);
        branch_addr_i <= a;
        branch_i <= 1;
        user_mode_i <= m;
        @(posedge core_clk_i);
        branch_i <= 0;
        pc = a;
    endtask
    task automatic agen(input logic [23:0] w, input logic lb, input logic [17:0] ea);
        int i;
        @(posedge core_clk_i);
        instr_word_i <= w;
        instr_load_i <= 1;
        long_branch_i <= lb;
        r = rnd();
        lat <= r[1:0] + 3'h1;
        @(posedge core_clk_i);
        instr_load_i <= 0;
        ea_q.push_back({28'h0, user_mode_i, ea});
        repeat (2) @(posedge core_clk_i);
        agen_start_i <= 1;
        @(posedge core_clk_i);
        agen_start_i <= 0;
        for (i = 0; i < 60; i++) begin
            @(posedge core_clk_i);
            #1 if (!agen_busy_o) break;
        end
        if (i == 60) begin
            num_errors++;
            print_verdict();
        end
    endtask
    // ==================================================
    // Result watcher
    always @(posedge core_clk_i) rd_tag_d <= rd_tag;
    always @(negedge core_clk_i) begin
        if (rd_tag_d) check("register", rd_data_o, rd_q.pop_front());
        if (ea_valid_o) check("address", {28'h0, ea_xlate_o, ea_o}, ea_q.size() ? ea_q.pop_front() : '1);
    end
    initial begin
        xr[0] = 24'h0;
        repeat (8) @(posedge core_clk_i);
        reset_n_i <= 1;
        repeat (3) @(posedge core_clk_i);
        @(posedge core_clk_i);
        io_load_i <= 1;
        acc = rnd();
        io_data_i <= acc;
        @(posedge core_clk_i);
        io_load_i <= 0;
        wr(`CRA_SEL_BYTE, 47'h5A);
        acc[7:0] = 8'h5A;
        rd(`CRA_SEL_ACC, acc);
        d = {rnd(), rnd()};
        wr(`CRA_SEL_DBL, d);
        acc[22:0] = d[22:0];
        rd(`CRA_SEL_ACC, acc);
        rd(`CRA_SEL_EXT, d[46:23]);
        rd(`CRA_SEL_DBL, d);
        rd(`CRA_SEL_BYTE, acc[7:0]);
        for (k = 1; k < 4; k++) begin
            xr[k] = rnd();
            wr(4'h3 + k[3:0], xr[k]);
        end
        for (k = 1; k < 4; k++) rd(4'h3 + k[3:0], xr[k]);
        @(posedge core_clk_i);
        cond_upd_i <= 1;
        cond_val_i <= 4'h6;
        wr(`CRA_SEL_COND, 47'h9);
        cond_upd_i <= 0;
        rd(`CRA_SEL_COND, 47'h6);
        setpc(16'h7FFF, 0);
        rd(`CRA_SEL_PC, 47'h7FFF);
        @(posedge core_clk_i);
        pc_inc_i <= 1;
        @(posedge core_clk_i);
        pc_inc_i <= 0;
        rd(`CRA_SEL_PC, 47'h8000);
        @(posedge core_clk_i);
        branch_save_link_instr_i <= 1;
        branch_addr_i <= 16'h1234;
        @(posedge core_clk_i);
        branch_save_link_instr_i <= 0;
        rd(`CRA_SEL_PC, 47'h1234);
        $display("register tests done");
        for (k = 0; k < 8; k++) begin
            r = rnd();
            setpc({k[2], r[14:0]}, k[0] ^ k[2]);
            ir = rnd();
            ir[17:15] = {1'b0, k[1:0]};
            agen(ir, 0, dir_ea(ir));
        end
        wr(`CRA_SEL_INSTR, 47'h0);
        wr(`CRA_SEL_SHIFT, 47'h3C);
        rd(`CRA_SEL_INSTR, {ir[23:8], 8'h3C});
        for (k = 0; k < 2; k++) begin
            ir = rnd();
            ir[17:16] = {1'b0, k[0]};
            agen(ir, 1, {2'h0, ir[15:0]});
        end
        $display("direct tests done");
        for (k = 0; k < 5; k++) begin
            setpc(16'h8000 | rnd(), k[0]);
            ir = rnd();
            ir[17:15] = 3'h5;
            e0 = (k == 4) ? {2'h0, ir[15:0]} : dir_ea(ir);
            r = rnd();
            w1 = {1'b1, k[1] ? 2'h2 : 2'h0, 5'h0, r[15:0]};
            e1 = {2'h0, w1[15:0] + xr[w1[22:21]][15:0]};
            r = rnd();
            w2 = {1'b0, k[1:0], k[0] ^ k[1] ^ k[2], r[19:0]};
            fin = w2[20] ? w2[17:0] + xr[w2[22:21]][17:0] : {2'h0, w2[15:0] + xr[w2[22:21]][15:0]};
            mdl.mem[e0] = w1;
            mdl.mem[e1] = w2;
            agen(ir, k == 4, fin);
        end
        $display("indirect tests done");
        check("leftover", ea_q.size() + rd_q.size(), 47'h0);
        print_verdict();
    end
endmodule // cra_core_bench
`default_nettype wire
